// *** qr_sw_pkg.sv ***
// shared constants, states and carriers for the flyback switch sequencer
package qr_sw_pkg;

  // clock and documented times
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int T_BLANK_MAX_NS  = 16000;
  localparam int T_BLANK_MIN_NS  = 4160;
  localparam int T_FORCE_NS      = 2700;
  localparam int T_VALLEY_DLY_NS = 197;
  localparam int T_ON_MAX_NS     = 10000;
  localparam int F_SW_MAX_KHZ    = 240;

  // least time, rounded up to whole cycles
  function automatic int ceil_cyc(input int ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction

  localparam int BLANK_MAX_CYC  = ceil_cyc(T_BLANK_MAX_NS);
  localparam int BLANK_MIN_CYC  = ceil_cyc(T_BLANK_MIN_NS);
  localparam int FORCE_CYC      = ceil_cyc(T_FORCE_NS);
  localparam int VALLEY_DLY_CYC = ceil_cyc(T_VALLEY_DLY_NS);
  // longest on time rounded down, least switching period rounded up
  localparam int ON_MAX_CYC     = (T_ON_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int MIN_PERIOD_CYC =
    (1_000_000_000 + F_SW_MAX_KHZ * CLK_PERIOD_PS - 1) / (F_SW_MAX_KHZ * CLK_PERIOD_PS);

  // widths; feedback code is 10 mV per step
  localparam int CNT_W        = 12;
  localparam int VAL_W        = 4;
  localparam int FB_W         = 8;
  localparam int FB_BURST_CODE = 70;
  localparam int FB_FOLD_CODE  = 115;

  typedef enum logic [2:0] {
    CY_IDLE  = 3'h0,
    CY_ON    = 3'h1,
    CY_BLANK = 3'h3,
    CY_WAIT  = 3'h2,
    CY_ALIGN = 3'h6
  } cyc_state_t;

  typedef enum logic [2:0] {
    PW_CHARGE   = 3'h0,
    PW_CUT_SRC  = 3'h1,
    PW_CLAMP    = 3'h3,
    PW_SWITCHES = 3'h2,
    PW_SENSE    = 3'h6,
    PW_RUN      = 3'h7
  } pwr_state_t;

  // comparator decisions, high when the named condition holds
  typedef struct packed {
    logic zcd_arm;       // sense above arming level
    logic zcd_trig;      // sense below trigger level
    logic cs_trip;       // peak current reached
    logic burst_low;     // feedback below burst threshold minus hysteresis
    logic burst_high;    // feedback at or above burst threshold
    logic vlock_low;     // feedback below 1.3 V
    logic vlock_high;    // feedback at or above 1.43 V
    logic fold_threshold;      // supply above fold threshold
    logic vdd_reg_on;    // supply above regulator-on threshold
    logic vdd_start;     // supply above start threshold
    logic vdd_stop_low;  // supply below stop threshold
    logic vdd_undervoltage_lockout_low;  // supply below undervoltage lockout
    logic drv_good;      // driver supply above good threshold
    logic drv_low;       // driver supply below good minus hysteresis
    logic drv_over;      // driver supply above about 7 V
  } cmp_in_t;

  localparam int CMP_W = $bits(cmp_in_t);

  typedef struct packed {
    logic startup_src_en;
    logic startup_src_full;
    logic regulator_en;
    logic startup_gate_switch_open;
    logic hv_clamp_en;
    logic gate_pulldown_switch_closed;
    logic line_sense_link_switch_closed;
    logic low_side_sense_transistor_on;
  } pwr_ctl_t;

  localparam pwr_ctl_t PWR_CTL_RST = 8'h80;

  typedef struct packed {
    logic burst_pause;
    logic valley_lock_on;
    logic demag_locked;
  } status_t;

endpackage

// *** cmp_sync.sv ***
// two-flop synchronisers with edge detection on the synchronised levels
module cmp_sync #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // raw comparator outputs
  input  wire logic [W-1:0] raw,
  // synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] prev;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta  <= '0;
      level <= '0;
      prev  <= '0;
    end else if (clk_en) begin
      meta  <= raw;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule // cmp_sync

// *** qr_flyback_switch_sequencer.sv ***
// switching decision, burst and start-up sequencing of a quasi-resonant flyback
// How it works
// - triggered turn-on only after arm then trigger edge
// - blank trigger input after every turn-on
// - switching frequency stays below 240 kHz
// - blanking falls linearly from burst to foldback
// - valid edge after blanking, turn on after delay
// - edges inside blanking ignored, first later fires
// - force turn-on a fixed delay after blanking
// - starter drives cycles until sense arms trigger
// - valley lock holds skipped valley count constant
// - valley lock off below 1.3 V, on 1.43 V
// - feedback 60 mV below burst stops switching
// - burst pause ends at burst threshold again
// - start-up current reduced below fold threshold
// - regulator-on threshold enables driver regulator
// - start threshold runs the ordered switch sequence
// - no switching before driver supply good
// - gate suppressed while driver supply above 7 V
// - halt when driver supply below good minus hysteresis
// - below stop threshold stop, return to start-up
// - undervoltage downward crossing resets all control logic
module qr_flyback_switch_sequencer #(
  parameter int FB_W          = qr_sw_pkg::FB_W,
  parameter int FB_BURST_CODE = qr_sw_pkg::FB_BURST_CODE,
  parameter int FB_FOLD_CODE  = qr_sw_pkg::FB_FOLD_CODE
) (
  // clock, reset, enable
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  // comparator decisions and feedback code
  input  wire qr_sw_pkg::cmp_in_t  cmp_raw,
  input  wire logic [FB_W-1:0]     feedback_level,
  // gate command
  output logic                     gate_on,
  // supply structure controls
  output qr_sw_pkg::pwr_ctl_t      pwr_ctl,
  // operating status
  output qr_sw_pkg::status_t       status
);

  localparam int CW = qr_sw_pkg::CNT_W;
  localparam int VW = qr_sw_pkg::VAL_W;

  logic [qr_sw_pkg::CMP_W-1:0] lvl_v;
  logic [qr_sw_pkg::CMP_W-1:0] rise_v;
  qr_sw_pkg::cmp_in_t          lvl;
  qr_sw_pkg::cmp_in_t          rise;
  logic                        undervoltage_lockout_rst;
  logic                        rst_int;
  logic                        drv_ok;
  logic                        burst;
  logic                        vlock_on;
  logic                        reg_en;
  logic                        run;
  logic                        armed;
  logic                        demag_locked;
  logic                        locked_valid;
  logic [VW-1:0]               locked_n;
  logic [VW-1:0]               valley_idx;
  logic [VW-1:0]               idx_now;
  logic [CW-1:0]               cnt;
  logic [CW-1:0]               period_cnt;
  logic [CW-1:0]               blank_len;
  qr_sw_pkg::cyc_state_t       state;
  qr_sw_pkg::pwr_state_t       pw_state;
  logic                        lock_ok;
  logic                        fire_ok;
  logic                        force_on;
  logic                        align_on;
  logic                        turn_on;
  logic                        blank_done;
  logic                        period_ok;

  cmp_sync #(
    .W(qr_sw_pkg::CMP_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en (clk_en),
    .raw    (cmp_raw),
    .level  (lvl_v),
    .rise   (rise_v),
    .fall   ()
  );

  assign lvl  = qr_sw_pkg::cmp_in_t'(lvl_v);
  assign rise = qr_sw_pkg::cmp_in_t'(rise_v);

  // blanking length against feedback code
  function automatic logic [CW-1:0] blank_cycles(input logic [FB_W-1:0] fb);
    int d;
    d = 0;
    if (int'(fb) <= FB_BURST_CODE) begin
      return CW'(qr_sw_pkg::BLANK_MAX_CYC);
    end
    if (int'(fb) >= FB_FOLD_CODE) begin
      return CW'(qr_sw_pkg::BLANK_MIN_CYC);
    end
    d = (qr_sw_pkg::BLANK_MAX_CYC - qr_sw_pkg::BLANK_MIN_CYC) * (int'(fb) - FB_BURST_CODE)
        / (FB_FOLD_CODE - FB_BURST_CODE);
    return CW'(qr_sw_pkg::BLANK_MAX_CYC - d);
  endfunction

  // undervoltage crossing resets everything past the synchronisers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      undervoltage_lockout_rst <= 1'b0;
    end else if (clk_en) begin
      undervoltage_lockout_rst <= rise.vdd_undervoltage_lockout_low;
    end
  end

  assign rst_int = sys_rst | undervoltage_lockout_rst;

  // driver supply good with hysteresis
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      drv_ok <= 1'b0;
    end else if (clk_en) begin
      if (lvl.drv_good) begin
        drv_ok <= 1'b1;
      end else if (lvl.drv_low) begin
        drv_ok <= 1'b0;
      end
    end
  end

  // burst pause with hysteresis
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      burst <= 1'b0;
    end else if (clk_en) begin
      if (lvl.burst_low) begin
        burst <= 1'b1;
      end else if (lvl.burst_high) begin
        burst <= 1'b0;
      end
    end
  end

  // valley lock enable with hysteresis
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      vlock_on <= 1'b0;
    end else if (clk_en) begin
      if (lvl.vlock_low) begin
        vlock_on <= 1'b0;
      end else if (lvl.vlock_high) begin
        vlock_on <= 1'b1;
      end
    end
  end

  // start-up sequence
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      pw_state <= qr_sw_pkg::PW_CHARGE;
    end else if (clk_en) begin
      if (pw_state != qr_sw_pkg::PW_CHARGE && lvl.vdd_stop_low) begin
        pw_state <= qr_sw_pkg::PW_CHARGE;
      end else begin
        case (pw_state)
          qr_sw_pkg::PW_CHARGE: begin
            if (lvl.vdd_start) begin
              pw_state <= qr_sw_pkg::PW_CUT_SRC;
            end
          end
          qr_sw_pkg::PW_CUT_SRC:  pw_state <= qr_sw_pkg::PW_CLAMP;
          qr_sw_pkg::PW_CLAMP:    pw_state <= qr_sw_pkg::PW_SWITCHES;
          qr_sw_pkg::PW_SWITCHES: pw_state <= qr_sw_pkg::PW_SENSE;
          qr_sw_pkg::PW_SENSE:    pw_state <= qr_sw_pkg::PW_RUN;
          qr_sw_pkg::PW_RUN:      pw_state <= qr_sw_pkg::PW_RUN;
          default:                pw_state <= qr_sw_pkg::PW_CHARGE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      reg_en <= 1'b0;
    end else if (clk_en && lvl.vdd_reg_on) begin
      reg_en <= 1'b1;
    end
  end

  // supply structure outputs follow the sequence state; regulator enable is set at the regulator-on threshold and held until reset
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      pwr_ctl <= qr_sw_pkg::PWR_CTL_RST;
    end else if (clk_en) begin
      pwr_ctl.startup_src_en   <= pw_state == qr_sw_pkg::PW_CHARGE;
      pwr_ctl.startup_src_full <= pw_state == qr_sw_pkg::PW_CHARGE && lvl.fold_threshold;
      pwr_ctl.regulator_en     <= reg_en | lvl.vdd_reg_on;
      pwr_ctl.startup_gate_switch_open <= pw_state inside {qr_sw_pkg::PW_CLAMP,
        qr_sw_pkg::PW_SWITCHES, qr_sw_pkg::PW_SENSE, qr_sw_pkg::PW_RUN};
      pwr_ctl.hv_clamp_en <= pw_state inside {qr_sw_pkg::PW_CLAMP,
        qr_sw_pkg::PW_SWITCHES, qr_sw_pkg::PW_SENSE, qr_sw_pkg::PW_RUN};
      pwr_ctl.gate_pulldown_switch_closed <= pw_state inside {qr_sw_pkg::PW_SWITCHES,
        qr_sw_pkg::PW_SENSE, qr_sw_pkg::PW_RUN};
      pwr_ctl.line_sense_link_switch_closed <= pw_state inside {qr_sw_pkg::PW_SWITCHES,
        qr_sw_pkg::PW_SENSE, qr_sw_pkg::PW_RUN};
      pwr_ctl.low_side_sense_transistor_on <= pw_state inside {qr_sw_pkg::PW_SENSE,
        qr_sw_pkg::PW_RUN};
    end
  end

  // switching permitted
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      run <= 1'b0;
    end else if (clk_en) begin
      run <= pw_state == qr_sw_pkg::PW_RUN && drv_ok && !lvl.drv_over && !burst
             && !lvl.vdd_stop_low;
    end
  end

  // turn-on decisions
  assign idx_now    = (valley_idx == '1) ? valley_idx : VW'(valley_idx + 1'b1);
  assign lock_ok    = !vlock_on || !locked_valid || idx_now >= locked_n;
  assign fire_ok    = armed && rise.zcd_trig && lock_ok;
  assign blank_done = period_cnt >= blank_len;
  assign period_ok  = period_cnt >= CW'(qr_sw_pkg::MIN_PERIOD_CYC - 1);
  assign force_on   = state == qr_sw_pkg::CY_WAIT && !fire_ok
                      && cnt >= CW'(qr_sw_pkg::FORCE_CYC - 1);
  assign align_on   = state == qr_sw_pkg::CY_ALIGN
                      && cnt >= CW'(qr_sw_pkg::VALLEY_DLY_CYC - 1);
  assign turn_on    = run && (state == qr_sw_pkg::CY_IDLE || force_on || align_on);

  // switching cycle
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      state   <= qr_sw_pkg::CY_IDLE;
      gate_on <= 1'b0;
      cnt     <= '0;
    end else if (clk_en) begin
      if (!run) begin
        state   <= qr_sw_pkg::CY_IDLE;
        gate_on <= 1'b0;
        cnt     <= '0;
      end else begin
        case (state)
          qr_sw_pkg::CY_IDLE: begin
            state   <= qr_sw_pkg::CY_ON;
            gate_on <= 1'b1;
            cnt     <= '0;
          end
          qr_sw_pkg::CY_ON: begin
            if (rise.cs_trip || cnt >= CW'(qr_sw_pkg::ON_MAX_CYC - 1)) begin
              state   <= qr_sw_pkg::CY_BLANK;
              gate_on <= 1'b0;
              cnt     <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          qr_sw_pkg::CY_BLANK: begin
            if (blank_done && period_ok) begin
              state <= qr_sw_pkg::CY_WAIT;
              cnt   <= '0;
            end
          end
          qr_sw_pkg::CY_WAIT: begin
            if (fire_ok) begin
              state <= qr_sw_pkg::CY_ALIGN;
              cnt   <= '0;
            end else if (force_on) begin
              state   <= qr_sw_pkg::CY_ON;
              gate_on <= 1'b1;
              cnt     <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          qr_sw_pkg::CY_ALIGN: begin
            if (align_on) begin
              state   <= qr_sw_pkg::CY_ON;
              gate_on <= 1'b1;
              cnt     <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          default: begin
            state   <= qr_sw_pkg::CY_IDLE;
            gate_on <= 1'b0;
            cnt     <= '0;
          end
        endcase
      end
    end
  end

  // time since the last turn-on, and blanking latched at turn-on
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      period_cnt <= '0;
      blank_len  <= CW'(qr_sw_pkg::BLANK_MAX_CYC);
    end else if (clk_en) begin
      if (turn_on) begin
        period_cnt <= '0;
        blank_len  <= blank_cycles(feedback_level);
      end else if (period_cnt != '1) begin
        period_cnt <= period_cnt + 1'b1;
      end
    end
  end

  // trigger arming; an arming edge beats the clear at turn-on
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      armed <= 1'b0;
    end else if (clk_en) begin
      if (rise.zcd_arm) begin
        armed <= 1'b1;
      end else if (turn_on) begin
        armed <= 1'b0;
      end
    end
  end

  // valley counting and lock
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      valley_idx   <= '0;
      locked_n     <= '0;
      locked_valid <= 1'b0;
    end else if (clk_en) begin
      if (turn_on) begin
        valley_idx <= '0;
      end else if (rise.zcd_trig) begin
        valley_idx <= idx_now;
      end
      if (!vlock_on) begin
        locked_valid <= 1'b0;
      end
      if (run && state == qr_sw_pkg::CY_WAIT && fire_ok && (!vlock_on || !locked_valid)) begin
        locked_n     <= idx_now;
        locked_valid <= vlock_on;
      end
    end
  end

  // demagnetisation locking versus starter
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      demag_locked <= 1'b0;
    end else if (clk_en) begin
      if (run && align_on) begin
        demag_locked <= 1'b1;
      end else if (turn_on && !armed) begin
        demag_locked <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      status <= '0;
    end else if (clk_en) begin
      status.burst_pause    <= burst;
      status.valley_lock_on <= vlock_on;
      status.demag_locked   <= demag_locked;
    end
  end

  // checks
  localparam int DON_CYC = qr_sw_pkg::VALLEY_DLY_CYC;
  localparam int MIN_P   = qr_sw_pkg::MIN_PERIOD_CYC - 1;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst_int || !clk_en);

  sequence s_trigger;
    state == qr_sw_pkg::CY_WAIT && fire_ok && run;
  endsequence

  sequence s_aligned;
    ##DON_CYC (state == qr_sw_pkg::CY_ALIGN && !gate_on) ##1 gate_on;
  endsequence

  property p_align;
    @(posedge clk_sys) disable iff (rst_int || !clk_en || !run)
      s_trigger |-> s_aligned;
  endproperty

  a_fire_needs_arm: assert property (
    (state == qr_sw_pkg::CY_WAIT ##1 state == qr_sw_pkg::CY_ALIGN)
      |-> $past(armed && rise.zcd_trig))
    else $error("valley delay entered without armed trigger edge");
  a_blank_after_on: assert property ($fell(gate_on) && run |-> state == qr_sw_pkg::CY_BLANK)
    else $error("turn-off not followed by blanking");
  a_min_period: assert property (
    $rose(gate_on) && !$past(state == qr_sw_pkg::CY_IDLE) |-> $past(period_cnt) >= MIN_P)
    else $error("switching period shorter than minimum");
  a_valley_delay: assert property (p_align)
    else $error("turn-on not at valley delay after trigger");
  a_blank_ignore: assert property (
    state == qr_sw_pkg::CY_BLANK && run && !(blank_done && period_ok)
      |=> state == qr_sw_pkg::CY_BLANK)
    else $error("left blanking early");
  a_force_on: assert property (
    force_on && run |=> gate_on && state == qr_sw_pkg::CY_ON)
    else $error("forced turn-on missing");
  a_burst_halt: assert property (burst |-> ##2 !gate_on)
    else $error("gate active during burst pause");
  a_seq_order: assert property (
    pw_state == qr_sw_pkg::PW_SENSE |-> $past(pw_state) == qr_sw_pkg::PW_SWITCHES
      && $past(pw_state, 2) == qr_sw_pkg::PW_CLAMP)
    else $error("start-up sequence out of order");
  a_drv_gate: assert property ($rose(gate_on) |-> $past(drv_ok, 2))
    else $error("turn-on without driver supply good");
  a_undervoltage_lockout_reset: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
      undervoltage_lockout_rst |=> pw_state == qr_sw_pkg::PW_CHARGE && !gate_on && !armed)
    else $error("undervoltage crossing did not reset control");
  a_vlock_hyst: assert property (lvl.vlock_low |=> !vlock_on)
    else $error("valley lock still on below low threshold");

endmodule // qr_flyback_switch_sequencer

// *** qr_plant_model.sv ***
// behavioural power stage and feedback comparators facing the switch sequencer
module qr_plant_model (
  // clock
  input  wire logic               clk_sys,
  // gate command and scenario controls
  input  wire logic               gate_on,
  input  wire logic               ring_en,
  input  wire qr_sw_pkg::cmp_in_t sup,
  // comparator levels and age of the last trigger edge
  output qr_sw_pkg::cmp_in_t      cmp_raw,
  output int                      trig_age
);
  timeunit 1ns;
  timeprecision 1ps;
  int   on_cnt  = 0;
  int   off_cnt = 0;
  logic trig_q  = 1'b0;
  logic hi;
  always_ff @(posedge clk_sys) begin
    on_cnt   <= gate_on ? on_cnt + 1 : 0;
    off_cnt  <= gate_on ? 0 : off_cnt + 1;
    trig_q   <= cmp_raw.zcd_trig;
    trig_age <= (cmp_raw.zcd_trig && !trig_q) ? 1 : trig_age + 1;
  end
  // winding high through demagnetisation, then rings with a 40-cycle period
  assign hi = !gate_on && (off_cnt < 60 || ((off_cnt - 60) / 20) % 2 == 1);
  // without ringing the sense never reaches the arming level
  always_comb begin
    cmp_raw          = sup;
    cmp_raw.zcd_arm  = ring_en && hi;
    cmp_raw.zcd_trig = !(ring_en && hi);
    cmp_raw.cs_trip  = on_cnt >= 100;
  end
endmodule // qr_plant_model

// *** testbench.sv ***
// self-checking bench for the flyback switch sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [14:0] sup;
    logic [7:0]  fb;
    logic [10:0] mask;
    logic [10:0] val;
    int          per;
  } row_t;
  logic                clk_sys        = 1'b0;
  logic                sys_rst        = 1'b1;
  logic                ring_en        = 1'b0;
  qr_sw_pkg::cmp_in_t  sup            = '0;
  logic [7:0]          feedback_level = 8'h73;
  qr_sw_pkg::cmp_in_t  cmp_raw;
  logic                gate_on;
  qr_sw_pkg::pwr_ctl_t pwr_ctl;
  qr_sw_pkg::status_t  status;
  int                  trig_age;
  int                  mismatches = 0;
  int                  n_compared = 0;
  int                  cyc        = 0;
  int                  t_prev     = 0;
  int                  t_now      = 0;
  int                  per[3];
  row_t                rows[21];

  qr_flyback_switch_sequencer DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .cmp_raw(cmp_raw),
    .feedback_level(feedback_level), .gate_on(gate_on), .pwr_ctl(pwr_ctl), .status(status));
  qr_plant_model plant (
    .clk_sys(clk_sys), .gate_on(gate_on), .ring_en(ring_en), .sup(sup),
    .cmp_raw(cmp_raw), .trig_age(trig_age));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_vec(input string nm, input logic [10:0] exp, input logic [10:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_int(input string nm, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic wait_bits(input logic [10:0] mask, input logic [10:0] val);
    for (int i = 0; i < 12 && (({status, pwr_ctl} & mask) !== val); i++) @(negedge clk_sys);
    t_now = cyc;
    chk_vec("status and supply controls", val, {status, pwr_ctl} & mask);
  endtask

  task automatic wait_rise();
    int i;
    i = 0;
    while (gate_on !== 1'b0 && i < 3000) begin
      @(negedge clk_sys);
      i++;
    end
    while (gate_on !== 1'b1 && i < 6000) begin
      @(negedge clk_sys);
      i++;
    end
    t_prev = t_now;
    t_now = cyc;
  endtask

  task automatic gate_low();
    int n;
    n = 0;
    repeat (20) @(negedge clk_sys);
    repeat (2000) begin
      @(negedge clk_sys);
      if (gate_on !== 1'b0) n++;
    end
    chk_int("gate cycles while halted", 0, 0, n);
  endtask

  initial begin
    #400_000;
    mismatches++;
    complete_run();
  end

  initial begin
    rows = '{
      '{15'h0500, 8'h73, 11'h0C0, 11'h080, 0}, '{15'h0580, 8'h73, 11'h040, 11'h040, 0},
      '{15'h05C0, 8'h73, 11'h020, 11'h020, 0}, '{15'h05E0, 8'h73, 11'h080, 11'h000, 0},
      '{15'h05E0, 8'h73, 11'h018, 11'h018, 0}, '{15'h05E0, 8'h73, 11'h006, 11'h006, 0},
      '{15'h05E0, 8'h73, 11'h001, 11'h001, 0}, '{15'h05E0, 8'h73, 11'h000, 11'h000, -1},
      '{15'h05E4, 8'h73, 11'h000, 11'h000, 858}, '{15'h05E4, 8'h46, 11'h000, 11'h000, 2338},
      '{15'h05E4, 8'h5C, 11'h000, 11'h000, 1614}, '{15'h05E2, 8'h73, 11'h000, 11'h000, -1},
      '{15'h05E5, 8'h73, 11'h000, 11'h000, -1}, '{15'h05E4, 8'h73, 11'h000, 11'h000, 858},
      '{15'h09E4, 8'h73, 11'h400, 11'h400, 0}, '{15'h09E4, 8'h73, 11'h000, 11'h000, -1},
      '{15'h05E4, 8'h73, 11'h400, 11'h000, 0}, '{15'h05E4, 8'h73, 11'h000, 11'h000, 858},
      '{15'h06E4, 8'h73, 11'h200, 11'h000, 0}, '{15'h05E4, 8'h73, 11'h200, 11'h200, 0},
      '{15'h05F4, 8'h73, 11'h000, 11'h000, -1}};
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk_vec("state after reset", 11'h080, {status, pwr_ctl});
    foreach (rows[i]) begin
      @(posedge clk_sys);
      sup <= qr_sw_pkg::cmp_in_t'(rows[i].sup);
      feedback_level <= rows[i].fb;
      t_prev = t_now;
      if (rows[i].per > 0) begin
        repeat (3) wait_rise();
        chk_int("period", rows[i].per - 2, rows[i].per + 2, t_now - t_prev);
      end else if (rows[i].per < 0) begin
        gate_low();
      end else begin
        wait_bits(rows[i].mask, rows[i].val);
        if (i > 0 && rows[i].sup === rows[i-1].sup && rows[i-1].per == 0)
          chk_int("step cycle", t_prev + 1, 1 << 30, t_now);
      end
    end
    @(posedge clk_sys);
    sup <= qr_sw_pkg::cmp_in_t'(15'h05FC);
    wait_bits(11'h7BF, 11'h080);
    @(posedge clk_sys);
    sup <= qr_sw_pkg::cmp_in_t'(15'h05E4);
    wait_bits(11'h001, 11'h001);
    @(posedge clk_sys);
    ring_en <= 1'b1;
    repeat (3) wait_rise();
    for (int k = 0; k < 3; k++) begin
      wait_rise();
      per[k] = t_now - t_prev;
      chk_int("trigger to gate delay", 28, 30, trig_age);
      chk_int("triggered period", 521, 600, per[k]);
    end
    chk_int("repeated period", per[1], per[1], per[2]);
    chk_vec("demag locked", 11'h100, {status, 8'h00} & 11'h100);
    complete_run();
  end
endmodule // testbench
